// ==== hdl/async_serial_port.sv ====
// Asynchronous serial port with control register and timer baud
`timescale 1ns/1ps
module async_serial_port (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Special-function register bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Baud timer setup
    input wire logic timer_run,
    input wire serial_port_pkg::clk_src_t timer_clk_sel,
    input wire logic [7:0] baud_reload_value,
    input wire logic ext_osc,
    input wire logic external_timer_input,
    // Interrupt
    input wire logic irq_enable,
    output logic irq,
    // Serial pins
    input wire logic serial_receive_pin,
    output logic serial_transmit_pin
);
    import serial_port_pkg::*;

    timer_clock_if tc ();

    // Control register fields
    logic frame_format_select_q, address_filter_check_q, receiver_enable_bit_q;
    logic ninth_tx_bit_q, ninth_rx_bit_q, transmit_done_flag_q, receive_done_flag_q;

    // Bus
    logic ctrl_wr, data_wr, irq_q;
    logic [7:0] ctrl_view, sfr_rdata_q;

    // Baud timers
    logic [7:0] baud_timer_low_byte_q, rx_timer_q;
    logic tx_half_q, rx_half_q, tx_ovf, rx_ovf, tx_bit_tick, rx_sample;

    // Transmit
    frame_state_t tx_state_q;
    logic [7:0] tx_hold_q, tx_shift_q;
    logic [2:0] tx_cnt_q;
    logic tx_pending_q, tx_line_q, tx_take, tx_done_set;

    // Receive
    frame_state_t rx_state_q;
    logic [2:0] rx_sync_q, rx_cnt_q;
    logic [7:0] rx_shift_q, rx_latch_q;
    logic rx_ninth_q, rx_line, start_detect, rx_accept, rx_done_set;

    // Timer clock source
    assign tc.sel = timer_clk_sel;
    timer_clock_source #(.PRE_W(6)) u_clk_src (
        .mclk(mclk),
        .rst_b(rst_b),
        .ext_osc(ext_osc),
        .external_timer_input(external_timer_input),
        .tc(tc)
    );

    // Bus decode
    assign ctrl_wr = sfr_wr && (sfr_addr == CTRL_ADDR);
    assign data_wr = sfr_wr && (sfr_addr == DATA_ADDR);

    // Control view; bit 6 fixed at one [R18]
    assign ctrl_view = {frame_format_select_q, 1'b1, address_filter_check_q,
                        receiver_enable_bit_q, ninth_tx_bit_q, ninth_rx_bit_q,
                        transmit_done_flag_q, receive_done_flag_q};

    // Read data register; transmit data never visible [R05]
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            sfr_rdata_q <= 8'h00;
        else if (sfr_rd)
            sfr_rdata_q <= (sfr_addr == CTRL_ADDR) ? ctrl_view :
                           (sfr_addr == DATA_ADDR) ? rx_latch_q : 8'h00;
    end
    assign sfr_rdata = sfr_rdata_q;

    // Software-owned control bits; bit 6 write ignored [R08] [R12] [R16] [R18]
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            frame_format_select_q <= CTRL_RESET[MODE_BIT];
            address_filter_check_q <= CTRL_RESET[MCE_BIT];
            receiver_enable_bit_q <= CTRL_RESET[REN_BIT];
            ninth_tx_bit_q <= CTRL_RESET[TB8_BIT];
        end
        else if (ctrl_wr)
        begin
            frame_format_select_q <= sfr_wdata[MODE_BIT];
            address_filter_check_q <= sfr_wdata[MCE_BIT];
            receiver_enable_bit_q <= sfr_wdata[REN_BIT];
            ninth_tx_bit_q <= sfr_wdata[TB8_BIT];
        end
    end

    // Transmit-done flag: hardware set beats software clear [R07] [R11]
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            transmit_done_flag_q <= CTRL_RESET[TI_BIT];
        else if (tx_done_set)
            transmit_done_flag_q <= 1'b1;
        else if (ctrl_wr)
            transmit_done_flag_q <= sfr_wdata[TI_BIT];
    end

    // Receive-done flag: hardware set beats software clear [R07] [R17]
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            receive_done_flag_q <= CTRL_RESET[RI_BIT];
        else if (rx_done_set)
            receive_done_flag_q <= 1'b1;
        else if (ctrl_wr)
            receive_done_flag_q <= sfr_wdata[RI_BIT];
    end

    // Interrupt request while either flag stands [R07]
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            irq_q <= 1'b0;
        else
            irq_q <= irq_enable && (transmit_done_flag_q || receive_done_flag_q);
    end
    assign irq = irq_q;

    // Overflow strobes of both timers
    assign tx_ovf = timer_run && tc.tick && (baud_timer_low_byte_q == TIMER_TOP);
    assign rx_ovf = timer_run && tc.tick && (rx_timer_q == TIMER_TOP);
    assign tx_bit_tick = tx_ovf && tx_half_q; // Every second overflow [R01]

    // Transmit timer with auto-reload, overflow halved [R01]
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            baud_timer_low_byte_q <= 8'h00;
            tx_half_q <= 1'b0;
        end
        else if (timer_run && tc.tick)
        begin
            if (tx_ovf)
            begin
                baud_timer_low_byte_q <= baud_reload_value;
                tx_half_q <= !tx_half_q;
            end
            else
                baud_timer_low_byte_q <= baud_timer_low_byte_q + 8'h01;
        end
    end

    // Private receive timer, forced reload on start edge [R02] [R03]
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_timer_q <= 8'h00;
            rx_half_q <= 1'b0;
        end
        else if (start_detect)
        begin
            rx_timer_q <= baud_reload_value; // [R03]
            rx_half_q <= 1'b0;
        end
        else if (timer_run && tc.tick)
        begin
            if (rx_ovf)
            begin
                rx_timer_q <= baud_reload_value; // [R02]
                rx_half_q <= !rx_half_q;
            end
            else
                rx_timer_q <= rx_timer_q + 8'h01;
        end
    end

    // First overflow after reload lands mid start bit [R21] [R01]
    assign rx_sample = rx_ovf && !rx_half_q;

    // Pending send: new write wins over consumption
    assign tx_take = tx_bit_tick && tx_pending_q &&
                     ((tx_state_q == FR_IDLE) || (tx_state_q == FR_STOP));

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_pending_q <= 1'b0;
            tx_hold_q <= DATA_RESET;
        end
        else if (data_wr)
        begin
            tx_pending_q <= 1'b1; // [R11]
            tx_hold_q <= sfr_wdata; // [R05]
        end
        else if (tx_take)
            tx_pending_q <= 1'b0;
    end

    // Transmit end of data: stop time begins [R11]
    assign tx_done_set = tx_bit_tick &&
                         (((tx_state_q == FR_DATA) && (tx_cnt_q == LAST_DATA_BIT) &&
                           !frame_format_select_q) || (tx_state_q == FR_NINTH));

    // Transmit frame sequencer, line idles high [R09] [R10] [R21]
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_state_q <= FR_IDLE;
            tx_shift_q <= 8'h00;
            tx_cnt_q <= 3'h0;
            tx_line_q <= 1'b1;
        end
        else if (tx_take)
        begin
            tx_state_q <= FR_START;
            tx_shift_q <= tx_hold_q;
            tx_line_q <= 1'b0;
        end
        else if (tx_bit_tick)
        begin
            case (tx_state_q)
                FR_START:
                begin
                    tx_line_q <= tx_shift_q[0]; // Least significant first [R09]
                    tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                    tx_cnt_q <= 3'h0;
                    tx_state_q <= FR_DATA;
                end
                FR_DATA:
                begin
                    if (tx_cnt_q != LAST_DATA_BIT)
                    begin
                        tx_line_q <= tx_shift_q[0];
                        tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                        tx_cnt_q <= tx_cnt_q + 3'h1;
                    end
                    else if (frame_format_select_q)
                    begin
                        tx_line_q <= ninth_tx_bit_q; // [R10]
                        tx_state_q <= FR_NINTH;
                    end
                    else
                    begin
                        tx_line_q <= 1'b1;
                        tx_state_q <= FR_STOP;
                    end
                end
                FR_NINTH:
                begin
                    tx_line_q <= 1'b1;
                    tx_state_q <= FR_STOP;
                end
                default:
                begin
                    tx_line_q <= 1'b1;
                    tx_state_q <= FR_IDLE;
                end
            endcase
        end
    end
    assign serial_transmit_pin = tx_line_q;

    // Receive pin synchroniser plus edge history
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            rx_sync_q <= 3'h7;
        else
            rx_sync_q <= {rx_sync_q[1:0], serial_receive_pin};
    end

    assign rx_line = rx_sync_q[1];

    // Falling edge while idle and enabled [R12] [R21]
    assign start_detect = (rx_state_q == FR_IDLE) && receiver_enable_bit_q &&
                          rx_sync_q[2] && !rx_line;

    // Acceptance: flag clear plus stop or address check [R13] [R15] [R16]
    assign rx_accept = !receive_done_flag_q &&
                       (!address_filter_check_q ||
                        (frame_format_select_q ? rx_ninth_q : rx_line));
    assign rx_done_set = rx_sample && (rx_state_q == FR_STOP) && rx_accept; // [R17]

    // Receive frame sequencer with separate shifter [R06] [R09] [R10]
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_state_q <= FR_IDLE;
            rx_shift_q <= 8'h00;
            rx_cnt_q <= 3'h0;
            rx_ninth_q <= 1'b0;
        end
        else if (start_detect)
            rx_state_q <= FR_START;
        else if (rx_sample)
        begin
            case (rx_state_q)
                FR_START:
                begin
                    rx_cnt_q <= 3'h0;
                    rx_state_q <= rx_line ? FR_IDLE : FR_DATA; // False start
                end
                FR_DATA:
                begin
                    rx_shift_q <= {rx_line, rx_shift_q[7:1]};
                    rx_cnt_q <= rx_cnt_q + 3'h1;
                    if (rx_cnt_q == LAST_DATA_BIT)
                        rx_state_q <= frame_format_select_q ? FR_NINTH : FR_STOP;
                end
                FR_NINTH:
                begin
                    rx_ninth_q <= rx_line;
                    rx_state_q <= FR_STOP;
                end
                default:
                    rx_state_q <= FR_IDLE;
            endcase
        end
    end

    // Latch and ninth/stop bit load only on accept [R13] [R14] [R15]
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_latch_q <= DATA_RESET;
            ninth_rx_bit_q <= CTRL_RESET[RB8_BIT];
        end
        else if (rx_done_set)
        begin
            rx_latch_q <= rx_shift_q;
            ninth_rx_bit_q <= frame_format_select_q ? rx_ninth_q : rx_line;
        end
        else if (ctrl_wr)
            ninth_rx_bit_q <= sfr_wdata[RB8_BIT];
    end

endmodule // async_serial_port

// ==== hdl/serial_port_pkg.sv ====
// Constants and types shared by the asynchronous serial port
// Behaviour
// R01 - Baud equals timer overflow rate halved
// R02 - Receiver keeps private reloading timer copy
// R03 - Start edge forces receive timer reload
// R04 - Timer clock chosen from six sources
// R05 - Writes go transmit, reads return receive
// R06 - Receive shifter separate from receive latch
// R07 - Done flags request interrupt, software clears
// R08 - Control bit 7 selects frame format
// R09 - 8-bit frame: start, eight data, stop
// R10 - 9-bit frame adds ninth bit from control
// R11 - Data write starts send; flag at stop
// R12 - Control bit 4 enables reception
// R13 - 8-bit load: flag clear, stop check
// R14 - Failed load leaves latch and flag alone
// R15 - 9-bit load: ninth bit stored, filter
// R16 - Bit 5 checks stop or filters addresses
// R17 - Receive flag set at stop sampling
// R18 - Control bit 6 reads one, ignores writes
// R19 - Master marks address bytes with ninth one
// R20 - Slave software toggles filter per message
// R21 - Idle high; falling start; mid-bit sampling
package serial_port_pkg;

    // Register locations on the special-function bus and their reset values
    localparam logic [7:0] CTRL_ADDR = 8'h98;
    localparam logic [7:0] DATA_ADDR = 8'h99;
    localparam logic [7:0] CTRL_RESET = 8'h40;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // Control register field positions
    localparam int unsigned MODE_BIT = 7;
    localparam int unsigned FIXED_BIT = 6;
    localparam int unsigned MCE_BIT = 5;
    localparam int unsigned REN_BIT = 4;
    localparam int unsigned TB8_BIT = 3;
    localparam int unsigned RB8_BIT = 2;
    localparam int unsigned TI_BIT = 1;
    localparam int unsigned RI_BIT = 0;

    // Baud timer reloads after its top value (256 minus baud_reload_value counts per period)
    localparam logic [7:0] TIMER_TOP = 8'hFF;
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;

    // Timer clock source select codes
    typedef enum logic [2:0] {
        SRC_SYSTEM_CLOCK = 3'h0,
        SRC_DIV4 = 3'h1,
        SRC_DIV12 = 3'h2,
        SRC_DIV48 = 3'h3,
        SRC_EXTOSC_DIV8 = 3'h4,
        SRC_EXT_PIN = 3'h5
    } clk_src_t;

    // Prescaler divisors
    localparam int unsigned DIV_A = 4;
    localparam int unsigned DIV_B = 12;
    localparam int unsigned DIV_C = 48;
    localparam int unsigned EXTOSC_DIV = 8;

    // Frame state, Gray from idle to stop along the nine-bit path
    typedef enum logic [2:0] {
        FR_IDLE = 3'b000,
        FR_START = 3'b001,
        FR_DATA = 3'b011,
        FR_NINTH = 3'b010,
        FR_STOP = 3'b110
    } frame_state_t;

endpackage

// ==== hdl/timer_clock_if.sv ====
// Interface carrying the baud timer clock select and its tick
`timescale 1ns/1ps
interface timer_clock_if;
    import serial_port_pkg::*;
    clk_src_t sel;
    logic tick;
    modport source (input sel, output tick);
    modport user (output sel, input tick);
endinterface

// ==== hdl/timer_clock_source.sv ====
// Timer clock prescaler and external source selection
`timescale 1ns/1ps
module timer_clock_source #(
    parameter int unsigned PRE_W = 6
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // External clock pins
    input wire logic ext_osc,
    input wire logic external_timer_input,
    // Select and tick
    timer_clock_if.source tc
);
    import serial_port_pkg::*;

    // Prescaler must reach the largest divisor
    if ((2 ** PRE_W) < DIV_C)
    begin : g_check
        $error("timer_clock_source: PRE_W too small");
    end

    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(DIV_C - 1);

    logic [PRE_W-1:0] pre_q;
    logic [2:0] osc_sync_q, pin_sync_q, osc_cnt_q;
    logic osc_rise, pin_fall;

    // Tick when count ends a period of the given divisor
    function automatic logic div_end(input logic [PRE_W-1:0] cnt, input int unsigned div);
        div_end = ((32'(cnt) % div) == (div - 1));
    endfunction

    // Free-running prescaler common to the divided sources
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            pre_q <= '0;
        else if (pre_q == PRE_LAST)
            pre_q <= '0;
        else
            pre_q <= pre_q + 1'b1;
    end

    // Two-stage synchronisers plus history stage for edges
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            osc_sync_q <= 3'h0;
            pin_sync_q <= 3'h0;
        end
        else
        begin
            osc_sync_q <= {osc_sync_q[1:0], ext_osc};
            pin_sync_q <= {pin_sync_q[1:0], external_timer_input};
        end
    end

    assign osc_rise = osc_sync_q[1] && !osc_sync_q[2];
    assign pin_fall = !pin_sync_q[1] && pin_sync_q[2];

    // External oscillator divided by eight
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            osc_cnt_q <= 3'h0;
        else if (osc_rise)
            osc_cnt_q <= osc_cnt_q + 3'h1;
    end

    // Select one of six timer clock sources [R04]
    always_comb
    begin
        case (tc.sel)
            SRC_SYSTEM_CLOCK: tc.tick = 1'b1;
            SRC_DIV4: tc.tick = div_end(pre_q, DIV_A);
            SRC_DIV12: tc.tick = div_end(pre_q, DIV_B);
            SRC_DIV48: tc.tick = div_end(pre_q, DIV_C);
            SRC_EXTOSC_DIV8: tc.tick = osc_rise && (osc_cnt_q == 3'(EXTOSC_DIV - 1));
            SRC_EXT_PIN: tc.tick = pin_fall;
            default: tc.tick = 1'b0;
        endcase
    end

endmodule // timer_clock_source

// ==== testbench/async_serial_port_sva.sv ====
// Port-level assertions for the asynchronous serial port
`timescale 1ns/1ps
module async_serial_port_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // Baud timer
    input wire logic timer_run,
    input wire serial_port_pkg::clk_src_t timer_clk_sel,
    input wire logic [7:0] baud_reload_value,
    // Interrupt and pins
    input wire logic irq_enable,
    input wire logic irq,
    input wire logic serial_transmit_pin
);
    import serial_port_pkg::*;
    int low_cnt_q, bit_len;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    // Prescale factor of internally derived timer clocks
    always_comb
    begin
        case (timer_clk_sel)
            SRC_SYSTEM_CLOCK: bit_len = 1;
            SRC_DIV4: bit_len = DIV_A;
            SRC_DIV12: bit_len = DIV_B;
            SRC_DIV48: bit_len = DIV_C;
            default: bit_len = 0;
        endcase
    end
    // Length of the current low stretch on the line
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            low_cnt_q <= 0;
        else if (serial_transmit_pin)
            low_cnt_q <= 0;
        else
            low_cnt_q <= low_cnt_q + 1;
    end
    // Bus steps
    sequence ctrl_write_s;
        sfr_wr && !sfr_rd && sfr_addr == CTRL_ADDR;
    endsequence
    sequence ctrl_read_s;
        sfr_rd && !sfr_wr && sfr_addr == CTRL_ADDR;
    endsequence
    a_reset_out_idle: assert property ($rose(rst_b) |-> serial_transmit_pin && !irq && sfr_rdata == 8'h00)
        else $error("outputs not idle");
    a_fixed_bit_one: assert property (ctrl_read_s |=> sfr_rdata[6])
        else $error("control bit 6 read as zero");
    a_ctrl_write_back: assert property (ctrl_write_s ##1 !sfr_wr ##1 ctrl_read_s |=> (sfr_rdata & 8'hF8) == (($past(sfr_wdata, 3) & 8'hB8) | 8'h40))
        else $error("control bits lost");
    a_unmapped_reads_zero: assert property (sfr_rd && sfr_addr != CTRL_ADDR && sfr_addr != DATA_ADDR |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved");
    a_irq_masked: assert property (!irq_enable |=> !irq)
        else $error("interrupt while disabled");
    a_irq_tracks_flags: assert property (sfr_rd && sfr_addr == CTRL_ADDR && irq_enable |=> irq == (sfr_rdata[1:0] != 2'h0))
        else $error("irq disagrees with flags");
    a_tx_whole_bits: assert property (serial_transmit_pin && low_cnt_q != 0 && bit_len != 0 && timer_run |-> low_cnt_q % (bit_len * 2 * (256 - int'(baud_reload_value))) == 0)
        else $error("low time not whole bits");
endmodule // async_serial_port_checker

bind async_serial_port async_serial_port_checker chk_u (.mclk(mclk), .rst_b(rst_b),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .timer_run(timer_run), .timer_clk_sel(timer_clk_sel),
    .baud_reload_value(baud_reload_value), .irq_enable(irq_enable), .irq(irq),
    .serial_transmit_pin(serial_transmit_pin));

// ==== testbench/serial_node_model.sv ====
// Far serial node: frame sender and mid-bit sampling receiver
`timescale 1ns/1ps
module serial_node_model (
    // Clock
    input wire logic mclk,
    // Line pair
    input wire logic line_in,
    output logic line_out,
    // Frame setup
    input wire logic nine,
    input var int bit_cyc
);
    int rx_q[$];
    int v;
    initial line_out = 1'b1; // Idle high
    // Receiver: falling start edge, one sample mid-bit
    always
    begin
        @(negedge line_in);
        repeat (bit_cyc / 2) @(posedge mclk);
        v = 0;
        for (int i = 0; i < (nine ? 10 : 9); i++)
        begin
            repeat (bit_cyc) @(posedge mclk);
            v = v | (int'(line_in) << i);
        end
        rx_q.push_back(v);
    end
    // Sender, entered at a falling clock edge
    task automatic send(input logic [7:0] d, input logic b9, input logic stop);
        logic [10:0] f;
        f = nine ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            line_out = f[i];
            repeat (bit_cyc) @(negedge mclk);
        end
        line_out = 1'b1;
    endtask
endmodule // serial_node_model

// ==== testbench/test_async_serial_port.sv ====
// Self-checking bench for the asynchronous serial port
`timescale 1ns/1ps
module test_async_serial_port;
    import serial_port_pkg::*;
    logic mclk, rst_b, sfr_wr, sfr_rd, timer_run, ext_osc, external_timer_input;
    logic irq_enable, irq, serial_receive_pin, serial_transmit_pin, nine;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, baud_reload_value, rd_val, ctrl_ref, latch_ref;
    clk_src_t timer_clk_sel;
    int bit_cyc, error_cnt, cmp_count, ext_cnt, got;
    int bcs[6] = '{16, 64, 192, 768, 512, 96};
    async_serial_port dut_u (.mclk(mclk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer_run(timer_run),
        .timer_clk_sel(timer_clk_sel), .baud_reload_value(baud_reload_value), .ext_osc(ext_osc),
        .external_timer_input(external_timer_input), .irq_enable(irq_enable), .irq(irq),
        .serial_receive_pin(serial_receive_pin), .serial_transmit_pin(serial_transmit_pin));
    serial_node_model node_u (.mclk(mclk), .line_in(serial_transmit_pin),
        .line_out(serial_receive_pin), .nine(nine), .bit_cyc(bit_cyc));
    // Clock
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // External timer clocks: 4 and 6 cycle periods
    always @(negedge mclk)
    begin
        ext_cnt <= ext_cnt + 1;
        ext_osc <= ext_cnt[1];
        external_timer_input <= (ext_cnt % 6) < 3;
    end
    task automatic check(input logic [8:0] g, input logic [8:0] e, input string what);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error at %0t: %s got %h expected %h", $time, what, g, e);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge mclk);
        sfr_wr = 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge mclk);
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask
    // Control write mirrored into the reference
    task automatic set_ctrl(input logic [7:0] d);
        ctrl_ref = d | 8'h40;
        nine = d[7];
        reg_wr(CTRL_ADDR, d);
    endtask
    // Poll control until a flag in the mask rises
    task automatic wait_flag(input logic [7:0] m);
        int n;
        rd_val = 8'h00;
        for (n = 0; (rd_val & m) == 8'h00 && n < 20000; n++)
            reg_rd(CTRL_ADDR, rd_val);
        check({8'h00, n < 20000}, 9'h001, "flag wait");
    endtask
    // Send a byte and compare what the far node saw
    task automatic tx_byte(input clk_src_t s, input int bc, input logic m9, input logic tb8);
        logic [7:0] d = 8'($urandom);
        timer_clk_sel = s;
        bit_cyc = bc;
        set_ctrl({m9, 3'b000, tb8, 3'b000});
        reg_wr(DATA_ADDR, d);
        reg_rd(DATA_ADDR, rd_val);
        check({1'b0, rd_val}, {1'b0, latch_ref}, "data read");
        wait_flag(8'h02);
        check(9'(node_u.rx_q.size()), 9'h000, "done before stop");
        check({8'h00, irq}, 9'h001, "irq on send");
        for (int n = 0; n < 2 * bc && node_u.rx_q.size() == 0; n++) @(negedge mclk);
        got = node_u.rx_q.size() > 0 ? node_u.rx_q.pop_front() : 'h3FF;
        check(got[8:0], {m9 ? tb8 : 1'b1, d}, "sent frame");
        set_ctrl({m9, 7'h00});
        repeat (2) @(negedge mclk);
        check({8'h00, irq}, 9'h000, "irq after clear");
        repeat (bc) @(negedge mclk);
    endtask
    // Far node sends; reference decides acceptance
    task automatic rx_frame(input logic b9, input logic stop);
        logic [7:0] d = 8'($urandom);
        logic ok;
        repeat ($urandom_range(20, 0)) @(negedge mclk);
        node_u.send(d, b9, stop);
        ok = !ctrl_ref[0] && ctrl_ref[4] && (!ctrl_ref[5] || (nine ? b9 : stop));
        if (ok)
        begin
            latch_ref = d;
            ctrl_ref[2] = nine ? b9 : stop;
            ctrl_ref[0] = 1'b1;
        end
        reg_rd(CTRL_ADDR, rd_val);
        check({1'b0, rd_val & 8'h05}, {1'b0, ctrl_ref & 8'h05}, "rx flags");
        reg_rd(DATA_ADDR, rd_val);
        check({1'b0, rd_val}, {1'b0, latch_ref}, "rx latch");
    endtask
    task automatic test_done;
        $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog over the expected run length
    initial
    begin
        #2000000;
        error_cnt++;
        $display("Error at %0t: run hung", $time);
        test_done;
    end
    // Main sequence
    initial
    begin
        void'($urandom(3232));
        {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, ext_cnt, ext_osc, external_timer_input} = '0;
        {error_cnt, cmp_count, latch_ref, nine} = '0;
        timer_run = 1'b1;
        timer_clk_sel = SRC_SYSTEM_CLOCK;
        baud_reload_value = 8'hF8;
        bit_cyc = 16;
        irq_enable = 1'b1;
        rst_b = 1'b0;
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        rst_b = 1'b1;
        reg_rd(CTRL_ADDR, rd_val);
        check({1'b0, rd_val}, {1'b0, CTRL_RESET}, "control reset");
        reg_rd(8'h9A, rd_val);
        check({1'b0, rd_val}, 9'h000, "unmapped read");
        set_ctrl(8'hB8);
        reg_wr(8'h9A, 8'h55);
        reg_rd(CTRL_ADDR, rd_val);
        check({1'b0, rd_val}, 9'h0F8, "control write");
        $display("Test registers done");
        for (int i = 0; i < 6; i++)
            tx_byte(clk_src_t'(i), bcs[i], i[0], 1'($urandom));
        timer_clk_sel = SRC_SYSTEM_CLOCK;
        bit_cyc = 16;
        set_ctrl(8'h00);
        reg_wr(DATA_ADDR, 8'hA5);
        repeat (40) @(negedge mclk);
        reg_wr(DATA_ADDR, 8'h3C);
        for (int n = 0; n < 800 && node_u.rx_q.size() < 2; n++) @(negedge mclk);
        got = node_u.rx_q.size() == 2 ? node_u.rx_q.pop_front() : 0;
        check(got[8:0], 9'h1A5, "first queued");
        got = node_u.rx_q.size() == 1 ? node_u.rx_q.pop_front() : 0;
        check(got[8:0], 9'h13C, "second queued");
        $display("Test transmit done");
        rx_frame(1'b0, 1'b1);
        set_ctrl(8'h10);
        rx_frame(1'b0, 1'b1);
        rx_frame(1'b0, 1'b1);
        irq_enable = 1'b0;
        repeat (2) @(negedge mclk);
        check({8'h00, irq}, 9'h000, "irq masked");
        irq_enable = 1'b1;
        set_ctrl(8'h30);
        rx_frame(1'b0, 1'b0);
        rx_frame(1'b0, 1'b1);
        set_ctrl(8'hB0);
        rx_frame(1'b0, 1'b1);
        rx_frame(1'b1, 1'b0);
        set_ctrl(8'h90);
        rx_frame(1'b0, 1'b1);
        $display("Test receive done");
        reg_wr(DATA_ADDR, 8'h00);
        repeat (60) @(negedge mclk);
        rst_b = 1'b0;
        repeat (2) @(negedge mclk);
        rst_b = 1'b1;
        check({8'h00, serial_transmit_pin}, 9'h001, "line after reset");
        reg_rd(CTRL_ADDR, rd_val);
        check({1'b0, rd_val}, {1'b0, CTRL_RESET}, "control after reset");
        $display("Test mid-run reset done");
        test_done;
    end
endmodule // test_async_serial_port
